/* self_test_regs.sv */
// Self-test control, error total and local I2C clock width registers.
// Assumes an AXI4-Lite master on aclk and a synchronous low reset.
// Functional notes
// - The output mode gives no toggling for 00, alternating 1/0 for 01, self-test data when the top bit is set.
// - The oscillator field picks 50, 25 or 10 MHz for 00, 01, 10, and software avoids reserved 11.
// - The oscillator choice acts only while the automatic clock enable bit is set.
// - Pin configuration bit one means the pin configures self-test, zero means register bits 2:0 do.
// - When self-test starts, the clock source field is sent to the remote serializer offset 0x14.
// - The enable bit turns self-test on or off and resets to zero.
// - The error total reads the count of the port named by the second-port select.
// - The high width sets SCL high time in 50 ns units when acting as controller; the code times each unit as one 100 ns cycle.
// - The high width resets to 0x83.
// - The low width sets SCL low time in 50 ns units and resets to 0x84; the code times each unit as one 100 ns cycle.
// - The target uses the low width as SDA setup before releasing a held SCL.
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/10ps
module self_test_regs
	import st_regs_pkg::*;
(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address and data
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Self-test pins and link side
	input  wire logic        self_test_pin,
	input  wire logic [1:0]  link_err_pulse,
	input  wire logic        test_data_bit,
	output logic             test_out_q,
	output logic [1:0]       osc_clk_freq_sel_q,
	output logic             self_test_active_q,
	output logic             remote_csrc_wr_q,
	output logic [1:0]       remote_csrc_q,
	// I2C timing
	input  wire logic        i2c_ctl_run,
	input  wire logic        i2c_tgt_hold,
	output logic             scl_out_q,
	output logic             scl_release_q,
	// Interrupt
	output logic             irq_q
);
	import st_regs_pkg::*;

	logic [7:0]  ctrl_q;
	logic [7:0]  high_q;
	logic [7:0]  low_q;
	logic [7:0]  aux_q;
	logic [1:0]  ist_q;
	logic [1:0]  imask_q;
	logic [7:0]  err_total;
	logic [2:0]  pin_s_q;
	logic        pin_q;
	logic        en_eff;
	logic        en_prev_q;
	logic        err_seen;
	logic        aw_hold_q;
	logic        w_hold_q;
	logic [7:0]  aw_q;
	logic [31:0] wd_q;
	logic        wstb_q;
	logic        do_wr;
	logic        wr_hit;
	logic        irq_wr;

	// Byte lane 0 carries every narrow register; a byte address hits when it is four times the index.
	function automatic logic is_addr(input logic [7:0] a, input logic [7:0] off);
		return {2'b00, a[7:IDX_SHIFT]} == off && a[1:0] == 2'b00;
	endfunction

	// ==========================================================
	// Write channel: take address and data in either order.
	assign do_wr = aw_hold_q && w_hold_q && !s_axi_bvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q     <= 1'b0;
			w_hold_q      <= 1'b0;
			aw_q          <= 8'h00;
			wd_q          <= 32'h0000_0000;
			wstb_q        <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_hold_q && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_hold_q && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_q <= 1'b1;
				aw_q      <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_q <= 1'b1;
				wd_q     <= s_axi_wdata;
				wstb_q   <= s_axi_wstrb[0];
			end
			if (do_wr) begin
				aw_hold_q    <= 1'b0;
				w_hold_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	assign wr_hit = is_addr(aw_q, OFF_SELF_TEST_CTRL) || is_addr(aw_q, OFF_SELF_TEST_ERR_TOTAL)
		|| is_addr(aw_q, OFF_I2C_CLK_HIGH_WIDTH) || is_addr(aw_q, OFF_I2C_CLK_LOW_WIDTH)
		|| is_addr(aw_q, OFF_AUX_CTRL) || is_addr(aw_q, OFF_IRQ_STATUS) || is_addr(aw_q, OFF_IRQ_MASK);

	// ==========================================================
	// Register writes; the error total is read-only and ignores writes.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q  <= RST_SELF_TEST_CTRL;
			high_q  <= RST_HIGH_WIDTH;
			low_q   <= RST_LOW_WIDTH;
			aux_q   <= RST_AUX_CTRL;
			imask_q <= 2'h0;
		end else if (do_wr && wstb_q) begin
			if (is_addr(aw_q, OFF_SELF_TEST_CTRL)) begin
				ctrl_q <= wd_q[7:0];
			end
			if (is_addr(aw_q, OFF_I2C_CLK_HIGH_WIDTH)) begin
				high_q <= wd_q[7:0];
			end
			if (is_addr(aw_q, OFF_I2C_CLK_LOW_WIDTH)) begin
				low_q <= wd_q[7:0];
			end
			if (is_addr(aw_q, OFF_AUX_CTRL)) begin
				aux_q <= wd_q[7:0];
			end
			if (is_addr(aw_q, OFF_IRQ_MASK)) begin
				imask_q <= wd_q[1:0];
			end
		end
	end

	// ==========================================================
	// Read channel answers one cycle after the address is taken.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= RESP_OKAY;
				if (is_addr(s_axi_araddr, OFF_SELF_TEST_CTRL)) begin
					s_axi_rdata <= {24'h000000, ctrl_q};
				end else if (is_addr(s_axi_araddr, OFF_SELF_TEST_ERR_TOTAL)) begin
					s_axi_rdata <= {24'h000000, err_total};
				end else if (is_addr(s_axi_araddr, OFF_I2C_CLK_HIGH_WIDTH)) begin
					s_axi_rdata <= {24'h000000, high_q};
				end else if (is_addr(s_axi_araddr, OFF_I2C_CLK_LOW_WIDTH)) begin
					s_axi_rdata <= {24'h000000, low_q};
				end else if (is_addr(s_axi_araddr, OFF_AUX_CTRL)) begin
					s_axi_rdata <= {24'h000000, aux_q};
				end else if (is_addr(s_axi_araddr, OFF_IRQ_STATUS)) begin
					s_axi_rdata <= {30'h0, ist_q};
				end else if (is_addr(s_axi_araddr, OFF_IRQ_MASK)) begin
					s_axi_rdata <= {30'h0, imask_q};
				end else begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= RESP_SLVERR;
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Pin synchroniser: a change counts once stages two and three agree.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_s_q <= 3'h0;
			pin_q   <= 1'b0;
		end else begin
			pin_s_q <= {pin_s_q[1:0], self_test_pin};
			if (pin_s_q[1] == pin_s_q[2]) begin
				pin_q <= pin_s_q[2];
			end
		end
	end

	// Pin or register source for the enable.
	assign en_eff = ctrl_q[F_PIN_CFG] ? pin_q : ctrl_q[F_EN];

	// ==========================================================
	// Self-test state, remote clock source push and output pattern.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			en_prev_q          <= 1'b0;
			self_test_active_q <= 1'b0;
			remote_csrc_wr_q   <= 1'b0;
			remote_csrc_q      <= 2'h0;
			test_out_q         <= 1'b0;
		end else begin
			en_prev_q          <= en_eff;
			self_test_active_q <= en_eff;
			remote_csrc_wr_q   <= en_eff && !en_prev_q;
			if (en_eff && !en_prev_q) begin
				remote_csrc_q <= ctrl_q[F_CSRC_HI:F_CSRC_LO];
			end
			if (!en_eff || ctrl_q[F_OUT_MODE_HI:F_OUT_MODE_LO] == MODE_NONE) begin
				test_out_q <= 1'b0;
			end else if (ctrl_q[F_OUT_MODE_HI:F_OUT_MODE_LO] == MODE_ALT) begin
				test_out_q <= ~test_out_q;
			end else begin
				test_out_q <= test_data_bit;
			end
		end
	end

	// Oscillator select passes only with automatic clock enabled; reserved code holds 25 MHz.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			osc_clk_freq_sel_q <= OSC_50;
		end else if (aux_q[F_AUTO_CLK_EN]) begin
			osc_clk_freq_sel_q <= (ctrl_q[F_OSC_HI:F_OSC_LO] == OSC_RSVD) ? OSC_25
				: ctrl_q[F_OSC_HI:F_OSC_LO];
		end
	end

	// ==========================================================
	// Sticky interrupts; a set in the same cycle beats a write-one clear.
	assign err_seen = self_test_active_q && (|link_err_pulse);
	assign irq_wr   = do_wr && wstb_q && is_addr(aw_q, OFF_IRQ_STATUS);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ist_q <= 2'h0;
			irq_q <= 1'b0;
		end else begin
			ist_q[IRQ_ERR]       <= err_seen || (ist_q[IRQ_ERR] && !(irq_wr && wd_q[IRQ_ERR]));
			ist_q[IRQ_CSRC_SENT] <= remote_csrc_wr_q
				|| (ist_q[IRQ_CSRC_SENT] && !(irq_wr && wd_q[IRQ_CSRC_SENT]));
			irq_q                <= |(ist_q & ~imask_q); // A set mask bit hides its status bit.
		end
	end

	// ==========================================================
	// Submodules.
	err_counter u_err (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.run      (self_test_active_q),
		.clear    (en_eff && !en_prev_q),
		.err_pulse(link_err_pulse),
		.sel      (aux_q[F_SECOND_PORT]),
		.total_q  (err_total)
	);

	scl_timer u_scl (
		.aclk         (aclk),
		.aresetn      (aresetn),
		.high_width   (high_q),
		.low_width    (low_q),
		.ctl_run      (i2c_ctl_run),
		.tgt_hold     (i2c_tgt_hold),
		.scl_out_q    (scl_out_q),
		.scl_release_q(scl_release_q)
	);

	// ==========================================================
	// Checks.
	sequence start_s;
		en_eff && !en_prev_q;
	endsequence

	csrc_push_a: assert property (@(posedge aclk) disable iff (!aresetn)
		start_s |=> remote_csrc_wr_q && remote_csrc_q == $past(ctrl_q[F_CSRC_HI:F_CSRC_LO]))
		else $error("clock source not pushed on start");
	out_none_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl_q[F_OUT_MODE_HI:F_OUT_MODE_LO] == MODE_NONE |=> !test_out_q)
		else $error("output toggled in no-toggle mode");
	out_alt_a: assert property (@(posedge aclk) disable iff (!aresetn)
		en_eff && ctrl_q[F_OUT_MODE_HI:F_OUT_MODE_LO] == MODE_ALT |=> test_out_q != $past(test_out_q))
		else $error("alternating mode did not toggle");
	osc_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!aux_q[F_AUTO_CLK_EN] |=> $stable(osc_clk_freq_sel_q))
		else $error("oscillator select moved while auto clock off");
	osc_code_a: assert property (@(posedge aclk) disable iff (!aresetn)
		osc_clk_freq_sel_q != OSC_RSVD)
		else $error("reserved oscillator code reached output");
	pin_cfg_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!ctrl_q[F_PIN_CFG] |=> self_test_active_q == $past(ctrl_q[F_EN]))
		else $error("register enable not followed");
	err_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
		aux_q[F_SECOND_PORT] |=> err_total == $past(u_err.cnt_q[1]))
		else $error("error total not taken from second port");
	reset_val_a: assert property (@(posedge aclk)
		$rose(aresetn) |-> high_q == RST_HIGH_WIDTH && low_q == RST_LOW_WIDTH && !ctrl_q[F_EN])
		else $error("width reset values wrong");
	scl_release_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(i2c_tgt_hold) && low_q > 8'h02 |=> !scl_release_q [*2])
		else $error("target released SCL too early");

	// Register writes of the two width fields.
	sequence high_wr_s;
		do_wr && wstb_q && is_addr(aw_q, OFF_I2C_CLK_HIGH_WIDTH);
	endsequence
	sequence low_wr_s;
		do_wr && wstb_q && is_addr(aw_q, OFF_I2C_CLK_LOW_WIDTH);
	endsequence

	high_wr_a: assert property (@(posedge aclk) disable iff (!aresetn)
		high_wr_s |=> high_q == $past(wd_q[7:0]))
		else $error("high width write lost");
	low_wr_a: assert property (@(posedge aclk) disable iff (!aresetn)
		low_wr_s |=> low_q == $past(wd_q[7:0]))
		else $error("low width write lost");
	pin_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl_q[F_PIN_CFG] |=> self_test_active_q == $past(pin_q))
		else $error("pin enable not followed");
	csrc_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!(en_eff && !en_prev_q) |=> !remote_csrc_wr_q && $stable(remote_csrc_q))
		else $error("clock source pushed without a start");
	irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
		1'b1 |=> irq_q == $past(|(ist_q & ~imask_q)))
		else $error("interrupt level wrong");
	err_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
		err_seen |=> ist_q[IRQ_ERR])
		else $error("error status not set");
	b_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	r_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read response dropped early");
endmodule

/* st_regs_pkg.sv */
// Package for the self-test and local I2C timing register bank.
// Assumes a single 10 MHz clock domain and an AXI4-Lite register bus.
package st_regs_pkg;
	// ==========================================================
	// Register indices; the bus byte address is four times the index.
	localparam logic [7:0] OFF_SELF_TEST_CTRL      = 8'h24;
	localparam logic [7:0] OFF_SELF_TEST_ERR_TOTAL = 8'h25;
	localparam logic [7:0] OFF_I2C_CLK_HIGH_WIDTH  = 8'h26;
	localparam logic [7:0] OFF_I2C_CLK_LOW_WIDTH   = 8'h27;
	localparam logic [7:0] OFF_AUX_CTRL            = 8'h30;
	localparam logic [7:0] OFF_IRQ_STATUS          = 8'h31;
	localparam logic [7:0] OFF_IRQ_MASK            = 8'h32;
	// Index to byte address shift, needed because the printed offsets are not word aligned.
	localparam int         IDX_SHIFT               = 2;
	// ==========================================================
	// Field positions of self_test_ctrl
	localparam int         F_OUT_MODE_HI           = 7;
	localparam int         F_OUT_MODE_LO           = 6;
	localparam int         F_OSC_HI                = 5;
	localparam int         F_OSC_LO                = 4;
	localparam int         F_PIN_CFG               = 3;
	localparam int         F_CSRC_HI               = 2;
	localparam int         F_CSRC_LO               = 1;
	localparam int         F_EN                    = 0;
	// Field positions of aux_ctrl
	localparam int         F_AUTO_CLK_EN           = 5;
	localparam int         F_SECOND_PORT           = 0;
	// Interrupt bit positions
	localparam int         IRQ_ERR                 = 0;
	localparam int         IRQ_CSRC_SENT           = 1;
	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_SELF_TEST_CTRL      = 8'h08;
	localparam logic [7:0] RST_HIGH_WIDTH          = 8'h83;
	localparam logic [7:0] RST_LOW_WIDTH           = 8'h84;
	localparam logic [7:0] RST_AUX_CTRL            = 8'h00;
	// ==========================================================
	// Timing: pulse width unit and bus clock.
	localparam int         UNIT_NS                 = 50;
	localparam int         CLK_NS                  = 100;
	localparam int         UNIT_CYC                = (UNIT_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [7:0] MIN_HIGH_WIDTH          = 8'h07;
	// Output mode, oscillator select and bus response codes.
	localparam logic [1:0] MODE_NONE               = 2'h0;
	localparam logic [1:0] MODE_ALT                = 2'h1;
	localparam logic [1:0] OSC_50                  = 2'h0;
	localparam logic [1:0] OSC_25                  = 2'h1;
	localparam logic [1:0] OSC_10                  = 2'h2;
	localparam logic [1:0] OSC_RSVD                = 2'h3;
	localparam logic [1:0] RESP_OKAY               = 2'h0;
	localparam logic [1:0] RESP_SLVERR             = 2'h2;
endpackage

/* scl_timer.sv */
// Times SCL high and low phases and the target SDA setup hold-off.
// Assumes widths come straight from register flops on the same clock.
`timescale 1ns/10ps
module scl_timer
	import st_regs_pkg::*;
(
	// Clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// Widths in units of one 100 ns clock cycle
	input  wire logic [7:0] high_width,
	input  wire logic [7:0] low_width,
	// Controller and target requests
	input  wire logic       ctl_run,
	input  wire logic       tgt_hold,
	// Results
	output logic            scl_out_q,
	output logic            scl_release_q
);
	import st_regs_pkg::*;

	logic [15:0] cnt_q;

	// Converts a width in units to clock cycles, never under one.
	function automatic logic [15:0] to_cyc(input logic [7:0] w);
		logic [15:0] c;
		c = 16'(w) * 16'(UNIT_CYC);
		return (c == 16'h0000) ? 16'h0001 : c;
	endfunction

	// ==========================================================
	// Controller clock: high for high_width units, low for low_width.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q     <= 16'h0000;
			scl_out_q <= 1'b1;
		end else if (!ctl_run) begin
			cnt_q     <= 16'h0000;
			scl_out_q <= 1'b1;
		end else if (cnt_q + 16'h0001 >= to_cyc(scl_out_q ? high_width : low_width)) begin
			cnt_q     <= 16'h0000;
			scl_out_q <= ~scl_out_q;
		end else begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end

	// Target stretch: SCL is released only after the low width passes.
	logic [15:0] tcnt_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tcnt_q        <= 16'h0000;
			scl_release_q <= 1'b0;
		end else begin
			if (!tgt_hold) begin
				tcnt_q        <= 16'h0000;
				scl_release_q <= 1'b0;
			end else if (tcnt_q + 16'h0001 >= to_cyc(low_width)) begin
				scl_release_q <= 1'b1;
			end else begin
				tcnt_q <= tcnt_q + 16'h0001;
			end
		end
	end
endmodule

/* err_counter.sv */
// Two per-port saturating self-test error counters.
// Assumes error strobes are one-cycle pulses on the bus clock.
`timescale 1ns/10ps
module err_counter
	import st_regs_pkg::*;
(
	// Clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// Control
	input  wire logic       run,
	input  wire logic       clear,
	input  wire logic [1:0] err_pulse,
	input  wire logic       sel,
	// Selected total
	output logic [7:0]      total_q
);
	import st_regs_pkg::*;

	logic [7:0] cnt_q [2];

	// ==========================================================
	// Counters saturate so a long run never wraps back to a small value.
	always_ff @(posedge aclk) begin
		for (int i = 0; i < 2; i++) begin
			if (!aresetn || clear) begin
				cnt_q[i] <= 8'h00;
			end else if (run && err_pulse[i] && cnt_q[i] != 8'hFF) begin
				cnt_q[i] <= cnt_q[i] + 8'h01;
			end
		end
	end

	// Presents the port chosen by the second-port select.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			total_q <= 8'h00;
		end else begin
			total_q <= cnt_q[sel ? 1 : 0];
		end
	end
endmodule

/* self_test_and_i2c_timing_regs_tb.sv */
// Self-checking testbench for the self-test and local I2C clock width register bank.
// Assumes the bank stands alone: this bench is its AXI4-Lite master and drives every pin.
`timescale 1ns/10ps
module self_test_and_i2c_timing_regs_tb;
	import st_regs_pkg::*;

	// ==========================================================
	// Signals
	logic        aclk, aresetn;
	logic [7:0]  awaddr, araddr;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata, rd;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, rsp, err_pulse, osc_sel, csrc, last_csrc;
	logic        pin, data_bit, test_out, active, csrc_wr, ctl_run, tgt_hold, scl, rel, irq;
	int          err_total, n_tests, n_push;

	self_test_regs dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .self_test_pin(pin),
		.link_err_pulse(err_pulse), .test_data_bit(data_bit), .test_out_q(test_out),
		.osc_clk_freq_sel_q(osc_sel), .self_test_active_q(active), .remote_csrc_wr_q(csrc_wr),
		.remote_csrc_q(csrc), .i2c_ctl_run(ctl_run), .i2c_tgt_hold(tgt_hold), .scl_out_q(scl),
		.scl_release_q(rel), .irq_q(irq));

	// ==========================================================
	// Clock, and a monitor of pushes to the remote clock source, which may land inside a bus cycle.
	always #50 aclk = ~aclk;
	always @(posedge aclk) begin
		if (csrc_wr === 1'b1) begin
			n_push++;
			last_csrc = csrc;
		end
	end

	// ==========================================================
	// Shared tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// Each bus task starts one edge later, so a release and a new request never share a time step.
	// Addresses are register indices; the byte address on the bus is four times the index.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit aw_ok, w_ok, b_ok;
		aw_ok = 0;
		w_ok = 0;
		b_ok = 0;
		@(posedge aclk);
		awaddr <= {a[5:0], 2'b00};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!b_ok) begin
			@(posedge aclk);
			if (aw_ok && w_ok && bvalid === 1'b1) begin
				rsp = bresp;
				b_ok = 1;
				bready <= 1'b0;
			end
			if (!aw_ok && awready === 1'b1) begin
				aw_ok = 1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready === 1'b1) begin
				w_ok = 1;
				wvalid <= 1'b0;
			end
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		bit ar_ok, r_ok;
		ar_ok = 0;
		r_ok = 0;
		@(posedge aclk);
		araddr <= {a[5:0], 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!r_ok) begin
			@(posedge aclk);
			if (ar_ok && rvalid === 1'b1) begin
				rd = rdata;
				rsp = rresp;
				r_ok = 1;
				rready <= 1'b0;
			end
			if (!ar_ok && arready === 1'b1) begin
				ar_ok = 1;
				arvalid <= 1'b0;
			end
		end
		chk(rd, exp);
	endtask

	task automatic pulse(input logic [1:0] p);
		err_pulse <= p;
		@(posedge aclk);
		err_pulse <= 2'h0;
		@(posedge aclk);
	endtask

	// Cycles from a target hold request until SCL may be released.
	task automatic rel_cnt(output int n);
		n = 0;
		tgt_hold <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
		end while (rel !== 1'b1);
		tgt_hold <= 1'b0;
		while (rel === 1'b1) @(posedge aclk);
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset;
		rchk(OFF_SELF_TEST_CTRL, 32'h08);
		rchk(OFF_SELF_TEST_ERR_TOTAL, 32'h00);
		rchk(OFF_I2C_CLK_HIGH_WIDTH, 32'h83);
		rchk(OFF_I2C_CLK_LOW_WIDTH, 32'h84);
		chk(active, 1'b0);
		wr(8'h20, 32'h5A);
		chk(rsp, RESP_SLVERR);
		rchk(8'h20, 32'h00);
		chk(rsp, RESP_SLVERR);
		wr(OFF_SELF_TEST_ERR_TOTAL, 32'hFF);
		rchk(OFF_SELF_TEST_ERR_TOTAL, 32'h00);
		wr(OFF_I2C_CLK_HIGH_WIDTH, 32'hFFFFFF0B);
		rchk(OFF_I2C_CLK_HIGH_WIDTH, 32'h0B);
	endtask

	// The frequency choice must stay put until automatic clocking is on.
	task automatic t_osc;
		wr(OFF_AUX_CTRL, 32'h00);
		wr(OFF_SELF_TEST_CTRL, 32'h20);
		cyc(2);
		chk(osc_sel, OSC_50);
		wr(OFF_AUX_CTRL, 32'h20);
		for (int i = 0; i < 3; i++) begin
			wr(OFF_SELF_TEST_CTRL, 32'(i << 4));
			cyc(2);
			chk(osc_sel, 32'(i));
		end
	endtask

	// Register-driven start, per-port error totals and the interrupt path.
	task automatic t_start;
		n_push = 0;
		wr(OFF_SELF_TEST_CTRL, 32'h05);
		cyc(4);
		chk(n_push, 1);
		chk(last_csrc, 2'h2);
		chk(active, 1'b1);
		repeat (3) pulse(2'b01);
		pulse(2'b10);
		cyc(2);
		chk(irq, 1'b1);
		wr(OFF_AUX_CTRL, 32'h00);
		rchk(OFF_SELF_TEST_ERR_TOTAL, 32'h03);
		wr(OFF_AUX_CTRL, 32'h01);
		rchk(OFF_SELF_TEST_ERR_TOTAL, 32'h01);
		rchk(OFF_IRQ_STATUS, 32'h03);
		wr(OFF_IRQ_MASK, 32'h03);
		cyc(2);
		chk(irq, 1'b0);
		wr(OFF_IRQ_MASK, 32'h00);
		wr(OFF_IRQ_STATUS, 32'h01);
		rchk(OFF_IRQ_STATUS, 32'h02);
		chk(irq, 1'b1);
		wr(OFF_IRQ_STATUS, 32'h02);
		cyc(2);
		chk(irq, 1'b0);
		wr(OFF_SELF_TEST_CTRL, 32'h04);
		cyc(2);
		chk(active, 1'b0);
	endtask

	// The pin passes through a three-flop synchroniser, so six cycles are allowed to settle.
	task automatic t_pin;
		wr(OFF_SELF_TEST_CTRL, 32'h08);
		pin <= 1'b1;
		cyc(6);
		chk(active, 1'b1);
		pin <= 1'b0;
		cyc(6);
		chk(active, 1'b0);
		pin <= 1'b1;
		wr(OFF_SELF_TEST_CTRL, 32'h00);
		cyc(6);
		chk(active, 1'b0);
		pin <= 1'b0;
	endtask

	task automatic t_mode;
		logic p;
		int t;
		for (int m = 0; m < 4; m++) begin
			data_bit <= 1'b0;
			wr(OFF_SELF_TEST_CTRL, 32'(m << 6) | 32'h01);
			cyc(3);
			p = test_out;
			t = 0;
			repeat (8) begin
				@(posedge aclk);
				if (test_out !== p) t++;
				p = test_out;
			end
			chk(t, (m == 1) ? 8 : 0);
			if (m > 1) begin
				data_bit <= 1'b1;
				cyc(4);
				chk(test_out, 1'b1);
			end
		end
		wr(OFF_SELF_TEST_CTRL, 32'h00);
	endtask

	// The smallest legal high width gives the tightest timing case.
	task automatic t_scl;
		int h, l, a, b;
		wr(OFF_I2C_CLK_HIGH_WIDTH, {24'h0, MIN_HIGH_WIDTH});
		wr(OFF_I2C_CLK_LOW_WIDTH, 32'h09);
		ctl_run <= 1'b1;
		while (scl !== 1'b0) @(posedge aclk);
		while (scl !== 1'b1) @(posedge aclk);
		h = 0;
		l = 0;
		while (scl === 1'b1) begin
			h++;
			@(posedge aclk);
		end
		while (scl === 1'b0) begin
			l++;
			@(posedge aclk);
		end
		chk(h, 7 * UNIT_CYC);
		chk(l, 9 * UNIT_CYC);
		ctl_run <= 1'b0;
		wr(OFF_I2C_CLK_LOW_WIDTH, 32'h04);
		rel_cnt(a);
		wr(OFF_I2C_CLK_LOW_WIDTH, 32'h0C);
		rel_cnt(b);
		chk(b - a, 8 * UNIT_CYC);
	endtask

	// ==========================================================
	// Verdict, run order and watchdog
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		{aclk, aresetn, awaddr, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
		{wdata, wstrb, err_pulse, pin, data_bit, ctl_run, tgt_hold} = '0;
		wstrb = 4'hF;
		err_total = 0;
		n_tests = 0;
		n_push = 0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset;
		t_osc;
		t_start;
		t_pin;
		t_mode;
		t_scl;
		end_sim;
	end

	// The whole sequence needs well under a thousand cycles.
	initial begin
		repeat (5000) @(posedge aclk);
		err_total++;
		end_sim;
	end
endmodule
